// [src/fsce_pkg.sv]
// Purpose: constants, types and helpers for the fault status character encoder
// Assumes: one clock i_ref_clk at 20 MHz, synchronous active-high reset
// Notes:   characters are 7 bits, letter order f through r
//
// Overview of operation
// - every character has bit 6 set
// - first category character carries stored count 0..10
// - demod character 3: configuration in bit 4
// - transmit character 2 flag layout
// - transmit character 3: audio clips bits 5,4
// - receive character 1: insert fault bit 5
// - receive character 2 flag layout
// - receive character 3 flag layout
// - receive character 4: audio clips bits 5,4
// - common character 1: module faults bits 5,4
// - common character 2: supply and battery faults
// - backward character 1: tx alarms 1,2
// - backward character 2: tx 3,4, rx 1..4
// - unavailable seconds character: count, bits 5,4 zero
package fsce_pkg;

    // =========================================================
    // character sequence
    localparam int unsigned N_CHARS   = 13;
    localparam logic [3:0]  CH_DM3    = 4'h0;
    localparam logic [3:0]  CH_TX1    = 4'h1;
    localparam logic [3:0]  CH_TX2    = 4'h2;
    localparam logic [3:0]  CH_TX3    = 4'h3;
    localparam logic [3:0]  CH_RX1    = 4'h4;
    localparam logic [3:0]  CH_RX2    = 4'h5;
    localparam logic [3:0]  CH_RX3    = 4'h6;
    localparam logic [3:0]  CH_RX4    = 4'h7;
    localparam logic [3:0]  CH_CE1    = 4'h8;
    localparam logic [3:0]  CH_CE2    = 4'h9;
    localparam logic [3:0]  CH_BA1    = 4'ha;
    localparam logic [3:0]  CH_BA2    = 4'hb;
    localparam logic [3:0]  CH_RS     = 4'hc;
    localparam logic [3:0]  CNT_MAX   = 4'ha;

    // =========================================================
    // registers
    localparam logic [7:0]  ADDR_CTRL = 8'h00;
    localparam logic [7:0]  ADDR_STAT = 8'h04;
    localparam logic [7:0]  ADDR_MASK = 8'h08;
    localparam logic [7:0]  ADDR_CNT  = 8'h0c;
    localparam int unsigned CTRL_POLL = 0;
    localparam int unsigned CTRL_CLR  = 1;
    localparam int unsigned STAT_DONE = 0;
    localparam int unsigned STAT_NEW  = 1;
    localparam int unsigned STAT_BUSY = 8;
    localparam logic [1:0]  STAT_RST  = 2'h0;
    localparam logic [1:0]  MASK_RST  = 2'h0;

    // =========================================================
    // types
    typedef struct packed {
        logic       one;
        logic       b5;
        logic       b4;
        logic [3:0] low;
    } fsce_char_s;

    typedef enum logic [0:0] {S_IDLE, S_RUN} fsce_ser_e;

    function automatic fsce_char_s mk_char(input logic b5, input logic b4,
                                           input logic [3:0] low);
        mk_char.one = 1'b1;
        mk_char.b5  = b5;
        mk_char.b4  = b4;
        mk_char.low = low;
    endfunction : mk_char

endpackage : fsce_pkg

// [src/fsce_seq_if.sv]
// Purpose: link between register logic and character serializer
// Assumes: same clock on both sides
// Notes:   ctl fills the characters, ser walks them
`timescale 1ns/100ps
interface fsce_seq_if;
    logic                                        start;
    fsce_pkg::fsce_char_s [fsce_pkg::N_CHARS-1:0] chars;
    logic [6:0]                                  ch;
    logic                                        vld;
    logic [3:0]                                  idx;
    logic                                        busy;
    logic                                        done;
    modport ctl (output start, chars, input ch, vld, idx, busy, done);
    modport ser (input start, chars, output ch, vld, idx, busy, done);
endinterface : fsce_seq_if

// [src/fsce_count.sv]
// Purpose: saturating stored-fault counter for one category
// Assumes: flags are levels from logic on i_ref_clk
// Notes:   a rising flag counts one; clear and event together keep the event
`timescale 1ns/100ps
module fsce_count #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_flags,
    input  wire logic         i_clear,
    output logic [3:0]        o_count,
    output logic              o_new
);
    typedef struct packed {
        logic [W-1:0] prev;
        logic [3:0]   cnt;
        logic         nw;
    } fsce_cnt_s;

    fsce_cnt_s q;
    fsce_cnt_s d;
    logic      rise;

    always_comb begin
        d      = q;
        rise   = |(i_flags & ~q.prev);
        d.prev = i_flags;
        d.nw   = rise;
        if (i_clear) begin
            d.cnt = 4'h0;
        end
        if (rise && (d.cnt < fsce_pkg::CNT_MAX)) begin
            d.cnt = d.cnt + 4'h1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_count = q.cnt;
    assign o_new   = q.nw;

    a_count_range: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        q.cnt <= fsce_pkg::CNT_MAX) else $error("stored count above ten");
    a_count_step: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (rise && !i_clear && q.cnt < fsce_pkg::CNT_MAX) |=> (q.cnt == $past(q.cnt) + 4'h1))
        else $error("stored count missed a fault");
endmodule : fsce_count

// [src/fsce_ser.sv]
// Purpose: walks the status characters out one per clock
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes:   character is sampled in the cycle before it appears
`timescale 1ns/100ps
module fsce_ser (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    fsce_seq_if.ser  sif
);
    typedef struct packed {
        fsce_pkg::fsce_ser_e st;
        logic [3:0]          walk;
        logic [3:0]          idx;
        logic [6:0]          ch;
        logic                vld;
        logic                done;
    } fsce_ser_s;

    fsce_ser_s q;
    fsce_ser_s d;

    always_comb begin
        d      = q;
        d.vld  = 1'b0;
        d.done = 1'b0;
        case (q.st)
            fsce_pkg::S_IDLE: begin
                if (sif.start) begin
                    d.st   = fsce_pkg::S_RUN;
                    d.walk = fsce_pkg::CH_DM3;
                end
            end
            fsce_pkg::S_RUN: begin
                d.vld = 1'b1;
                d.idx = q.walk;
                d.ch  = sif.chars[q.walk];
                if (q.walk == fsce_pkg::CH_RS) begin
                    d.st   = fsce_pkg::S_IDLE;
                    d.done = 1'b1;
                end else begin
                    d.walk = q.walk + 4'h1;
                end
            end
            default: begin
                d.st = fsce_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sif.ch   = q.ch;
    assign sif.vld  = q.vld;
    assign sif.idx  = q.idx;
    assign sif.busy = (q.st == fsce_pkg::S_RUN);
    assign sif.done = q.done;

    a_seq_order: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (q.vld && q.idx != fsce_pkg::CH_RS) |=> (q.vld && q.idx == $past(q.idx) + 4'h1))
        else $error("characters out of order");
    a_seq_first: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (q.st == fsce_pkg::S_IDLE && sif.start) |=> ##1 (q.vld && q.idx == fsce_pkg::CH_DM3))
        else $error("sequence did not open with first character");
    a_bit6_forced: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        q.vld |-> q.ch[6]) else $error("bit six low in status character");
    a_done_last: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        q.done |-> (q.vld && q.idx == fsce_pkg::CH_RS)) else $error("done without last character");
endmodule : fsce_ser

// [src/fsce_top.sv]
// Purpose: fault status character encoder with register port and interrupt
// Assumes: fault inputs are levels from logic on i_ref_clk
// Notes:   a write of poll sends all thirteen characters back to back
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
module fsce_top (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [31:0]      o_rdata,
    output logic             o_irq,
    output logic [6:0]       o_char,
    output logic             o_char_vld,
    output logic [3:0]       o_char_idx,
    input  wire logic        i_dm_cfg,
    input  wire logic        i_tx_ais,
    input  wire logic        i_tx_pll,
    input  wire logic        i_tx_clk,
    input  wire logic        i_tx_cfg,
    input  wire logic        i_tx_drop,
    input  wire logic        i_tx_clip1,
    input  wire logic        i_tx_clip2,
    input  wire logic        i_rx_ins,
    input  wire logic        i_rx_unf,
    input  wire logic        i_rx_ovf,
    input  wire logic        i_rx_los,
    input  wire logic        i_rx_fber,
    input  wire logic        i_rx_bwd,
    input  wire logic        i_rx_bclk,
    input  wire logic        i_rx_bpll,
    input  wire logic        i_rx_dmx,
    input  wire logic        i_rx_prbs,
    input  wire logic        i_rx_full,
    input  wire logic        i_rx_cfg,
    input  wire logic        i_rx_clip1,
    input  wire logic        i_rx_clip2,
    input  wire logic        i_ce_mc,
    input  wire logic        i_ce_ifm,
    input  wire logic        i_ce_batt,
    input  wire logic        i_ce_p5v,
    input  wire logic        i_ce_p12v,
    input  wire logic        i_ce_n12v,
    input  wire logic [3:0]  i_ba_tx,
    input  wire logic [3:0]  i_ba_rx,
    input  wire logic        i_rs_uas
);
    typedef struct packed {
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic [31:0] rdata;
        logic        irq;
        logic        start;
        logic        clr;
    } fsce_regs_s;

    fsce_regs_s q;
    fsce_regs_s d;
    fsce_seq_if sif ();

    logic [3:0] tx_cnt;
    logic [3:0] rx_cnt;
    logic [3:0] ce_cnt;
    logic [3:0] ba_cnt;
    logic [3:0] rs_cnt;
    logic [4:0] cat_new;
    logic [1:0] ev;
    logic [1:0] w1c;

    // =========================================================
    // stored fault counters
    fsce_count #(.W(7)) u_cnt_tx (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_flags   ({i_tx_ais, i_tx_pll, i_tx_clk, i_tx_cfg, i_tx_drop,
                     i_tx_clip1, i_tx_clip2}),
        .i_clear   (q.clr),
        .o_count   (tx_cnt),
        .o_new     (cat_new[0])
    );
    fsce_count #(.W(14)) u_cnt_rx (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_flags   ({i_rx_ins, i_rx_unf, i_rx_ovf, i_rx_los, i_rx_fber, i_rx_bwd,
                     i_rx_bclk, i_rx_bpll, i_rx_dmx, i_rx_prbs, i_rx_full,
                     i_rx_cfg, i_rx_clip1, i_rx_clip2}),
        .i_clear   (q.clr),
        .o_count   (rx_cnt),
        .o_new     (cat_new[1])
    );
    fsce_count #(.W(6)) u_cnt_ce (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_flags   ({i_ce_mc, i_ce_ifm, i_ce_batt, i_ce_p5v, i_ce_p12v, i_ce_n12v}),
        .i_clear   (q.clr),
        .o_count   (ce_cnt),
        .o_new     (cat_new[2])
    );
    fsce_count #(.W(8)) u_cnt_ba (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_flags   ({i_ba_tx, i_ba_rx}),
        .i_clear   (q.clr),
        .o_count   (ba_cnt),
        .o_new     (cat_new[3])
    );
    fsce_count #(.W(1)) u_cnt_rs (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_flags   (i_rs_uas),
        .i_clear   (q.clr),
        .o_count   (rs_cnt),
        .o_new     (cat_new[4])
    );

    // =========================================================
    // character assembly
    always_comb begin
        sif.chars         = '0;
        sif.chars[fsce_pkg::CH_DM3] = fsce_pkg::mk_char(1'b0, i_dm_cfg, 4'h0);
        sif.chars[fsce_pkg::CH_TX1] = fsce_pkg::mk_char(1'b0, 1'b0, tx_cnt);
        sif.chars[fsce_pkg::CH_TX2] = fsce_pkg::mk_char(i_tx_ais, i_tx_pll,
            {i_tx_clk, 1'b0, i_tx_cfg, i_tx_drop});
        sif.chars[fsce_pkg::CH_TX3] = fsce_pkg::mk_char(i_tx_clip1, i_tx_clip2, 4'h0);
        sif.chars[fsce_pkg::CH_RX1] = fsce_pkg::mk_char(i_rx_ins, 1'b0, rx_cnt);
        sif.chars[fsce_pkg::CH_RX2] = fsce_pkg::mk_char(i_rx_unf, i_rx_ovf,
            {i_rx_los, i_rx_fber, i_rx_bwd, i_rx_bclk});
        sif.chars[fsce_pkg::CH_RX3] = fsce_pkg::mk_char(i_rx_bpll, i_rx_dmx,
            {i_rx_prbs, i_rx_full, 1'b0, i_rx_cfg});
        sif.chars[fsce_pkg::CH_RX4] = fsce_pkg::mk_char(i_rx_clip1, i_rx_clip2, 4'h0);
        sif.chars[fsce_pkg::CH_CE1] = fsce_pkg::mk_char(i_ce_mc, i_ce_ifm, ce_cnt);
        sif.chars[fsce_pkg::CH_CE2] = fsce_pkg::mk_char(i_ce_batt, i_ce_p5v,
            {1'b0, i_ce_p12v, i_ce_n12v, 1'b0});
        sif.chars[fsce_pkg::CH_BA1] = fsce_pkg::mk_char(i_ba_tx[0], i_ba_tx[1], ba_cnt);
        sif.chars[fsce_pkg::CH_BA2] = fsce_pkg::mk_char(i_ba_tx[2], i_ba_tx[3],
            {i_ba_rx[0], i_ba_rx[1], i_ba_rx[2], i_ba_rx[3]});
        sif.chars[fsce_pkg::CH_RS]  = fsce_pkg::mk_char(1'b0, 1'b0, rs_cnt);
    end

    fsce_ser u_ser (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .sif       (sif)
    );

    // =========================================================
    // register port and interrupt
    always_comb begin
        d       = q;
        d.start = 1'b0;
        d.clr   = 1'b0;
        d.rdata = 32'h0000_0000;
        w1c     = 2'h0;
        ev      = 2'h0;
        ev[fsce_pkg::STAT_DONE] = sif.done;
        ev[fsce_pkg::STAT_NEW]  = |cat_new;
        if (i_wr) begin
            case (i_addr)
                fsce_pkg::ADDR_CTRL: begin
                    d.start = i_wdata[fsce_pkg::CTRL_POLL];
                    d.clr   = i_wdata[fsce_pkg::CTRL_CLR];
                end
                fsce_pkg::ADDR_STAT: begin
                    w1c = i_wdata[1:0];
                end
                fsce_pkg::ADDR_MASK: begin
                    d.mask = i_wdata[1:0];
                end
                default: begin
                    d.start = 1'b0;
                end
            endcase
        end
        d.stat = (q.stat & ~w1c) | ev;
        d.irq  = |(d.stat & d.mask);
        if (i_rd) begin
            case (i_addr)
                fsce_pkg::ADDR_STAT: begin
                    d.rdata[1:0]                = q.stat;
                    d.rdata[fsce_pkg::STAT_BUSY] = sif.busy;
                end
                fsce_pkg::ADDR_MASK: begin
                    d.rdata[1:0] = q.mask;
                end
                fsce_pkg::ADDR_CNT: begin
                    d.rdata[19:0] = {rs_cnt, ba_cnt, ce_cnt, rx_cnt, tx_cnt};
                end
                default: begin
                    d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            q       <= '0;
            q.stat  <= fsce_pkg::STAT_RST;
            q.mask  <= fsce_pkg::MASK_RST;
        end else begin
            q <= d;
        end
    end

    assign sif.start  = q.start;
    assign o_rdata    = q.rdata;
    assign o_irq      = q.irq;
    assign o_char     = sif.ch;
    assign o_char_vld = sif.vld;
    assign o_char_idx = sif.idx;

    // =========================================================
    // checks
    a_demod_char: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_DM3) |->
        (o_char == ({3'b100, 4'h0} | {2'b00, $past(i_dm_cfg), 4'h0})))
        else $error("demod character wrong");
    a_tx_count: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_TX1) |->
        (o_char == {3'b100, $past(tx_cnt)})) else $error("transmit count character wrong");
    a_tx2_char: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_TX2) |->
        (o_char == {1'b1, $past(i_tx_ais), $past(i_tx_pll), $past(i_tx_clk), 1'b0,
                    $past(i_tx_cfg), $past(i_tx_drop)})) else $error("transmit character 2 wrong");
    a_tx3_char: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_TX3) |->
        (o_char == {1'b1, $past(i_tx_clip1), $past(i_tx_clip2), 4'h0}))
        else $error("transmit character 3 wrong");
    a_rx1_char: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_RX1) |->
        (o_char == {1'b1, $past(i_rx_ins), 1'b0, $past(rx_cnt)}))
        else $error("receive character 1 wrong");
    a_rx2_char: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_RX2) |->
        (o_char == {1'b1, $past(i_rx_unf), $past(i_rx_ovf), $past(i_rx_los),
                    $past(i_rx_fber), $past(i_rx_bwd), $past(i_rx_bclk)}))
        else $error("receive character 2 wrong");
    a_rx3_char: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_RX3) |->
        (o_char == {1'b1, $past(i_rx_bpll), $past(i_rx_dmx), $past(i_rx_prbs),
                    $past(i_rx_full), 1'b0, $past(i_rx_cfg)}))
        else $error("receive character 3 wrong");
    a_rx4_char: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_RX4) |->
        (o_char == {1'b1, $past(i_rx_clip1), $past(i_rx_clip2), 4'h0}))
        else $error("receive character 4 wrong");
    a_ce1_char: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_CE1) |->
        (o_char == {1'b1, $past(i_ce_mc), $past(i_ce_ifm), $past(ce_cnt)}))
        else $error("common character 1 wrong");
    a_ce2_char: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_CE2) |->
        (o_char == {1'b1, $past(i_ce_batt), $past(i_ce_p5v), 1'b0, $past(i_ce_p12v),
                    $past(i_ce_n12v), 1'b0})) else $error("common character 2 wrong");
    a_ba1_char: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_BA1) |->
        (o_char == {1'b1, $past(i_ba_tx[0]), $past(i_ba_tx[1]), $past(ba_cnt)}))
        else $error("backward character 1 wrong");
    a_ba2_char: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_BA2) |->
        (o_char == {1'b1, $past(i_ba_tx[2]), $past(i_ba_tx[3]), $past(i_ba_rx[0]),
                    $past(i_ba_rx[1]), $past(i_ba_rx[2]), $past(i_ba_rx[3])}))
        else $error("backward character 2 wrong");
    a_rs_char: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (o_char_vld && o_char_idx == fsce_pkg::CH_RS) |->
        (o_char == {3'b100, $past(rs_cnt)})) else $error("unavailable seconds character wrong");
    a_irq_level: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        o_irq == |(q.stat & q.mask)) else $error("interrupt does not follow status");
    a_rdata_idle: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !$past(i_rd) |-> (o_rdata == 32'h0000_0000))
        else $error("read data outside read cycle");
    a_done_sticky: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        sif.done |=> q.stat[fsce_pkg::STAT_DONE])
        else $error("sequence done not latched");
    a_new_sticky: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (|cat_new) |=> q.stat[fsce_pkg::STAT_NEW])
        else $error("new stored fault not latched");
    a_stat_w1c: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_wr && i_addr == fsce_pkg::ADDR_STAT && i_wdata[0] && !sif.done)
        |=> !q.stat[fsce_pkg::STAT_DONE]) else $error("done flag not cleared");
    a_mask_write: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_wr && i_addr == fsce_pkg::ADDR_MASK) |=> (q.mask == $past(i_wdata[1:0])))
        else $error("mask write lost");
    a_clear_counts: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        q.clr |=> (tx_cnt <= 4'h1 && rx_cnt <= 4'h1 && ce_cnt <= 4'h1 &&
                   ba_cnt <= 4'h1 && rs_cnt <= 4'h1)) else $error("counts not cleared");
endmodule : fsce_top

// [sim/fsce_host.sv]
// Purpose: monitor host side, collects each polled character stream
// Assumes: characters arrive one per clock with index 0..12
// Notes:   listens only; the bench reads cap, n_chars and n_order
`timescale 1ns/100ps
module fsce_host (
    input  wire logic       i_ref_clk,
    input  wire logic [6:0] i_char,
    input  wire logic       i_char_vld,
    input  wire logic [3:0] i_char_idx
);
    logic [6:0]  cap [13];
    int unsigned n_chars = 0;
    int unsigned n_order = 0;
    logic [3:0]  nxt_idx = 4'h0;

    // =========================================================
    // capture
    always @(posedge i_ref_clk) begin
        if (i_char_vld === 1'b1) begin
            cap[i_char_idx] = i_char;
            if (i_char_idx !== nxt_idx) n_order++;
            nxt_idx = (nxt_idx == 4'hc) ? 4'h0 : nxt_idx + 4'h1;
            n_chars++;
        end
    end
endmodule : fsce_host

// [sim/testbench.sv]
// Purpose: self-checking bench for the fault status character encoder
// Assumes: register port with read data one cycle after the strobe
// Notes:   fault inputs come from one vector, counts are modelled here
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    localparam logic [36:0] CMASK [5] = '{37'h00000000fe, 37'h00003fff00,
        37'h000fc00000, 37'h0ff0000000, 37'h1000000000};
    localparam logic [36:0] PAT [5] = '{37'h0, '1, 37'h0aaaaaaaaa, 37'h1555555555, 37'h0};
    logic        i_ref_clk = 1'b0;
    logic        i_reset   = 1'b1;
    logic [7:0]  i_addr    = 8'h00;
    logic [31:0] i_wdata   = 32'h0;
    logic        i_wr      = 1'b0;
    logic        i_rd      = 1'b0;
    logic [36:0] flt       = 37'h0;
    logic [31:0] o_rdata;
    logic        o_irq;
    logic [6:0]  o_char;
    logic        o_char_vld;
    logic [3:0]  o_char_idx;
    logic [3:0]  cnt [5]   = '{default: 4'h0};
    logic [31:0] q;
    int unsigned err_count = 0;
    int unsigned checks_done = 0;

    fsce_top u_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_char(o_char), .o_char_vld(o_char_vld), .o_char_idx(o_char_idx),
        .i_dm_cfg(flt[0]), .i_tx_ais(flt[1]), .i_tx_pll(flt[2]), .i_tx_clk(flt[3]),
        .i_tx_cfg(flt[4]), .i_tx_drop(flt[5]), .i_tx_clip1(flt[6]), .i_tx_clip2(flt[7]),
        .i_rx_ins(flt[8]), .i_rx_unf(flt[9]), .i_rx_ovf(flt[10]), .i_rx_los(flt[11]),
        .i_rx_fber(flt[12]), .i_rx_bwd(flt[13]), .i_rx_bclk(flt[14]), .i_rx_bpll(flt[15]),
        .i_rx_dmx(flt[16]), .i_rx_prbs(flt[17]), .i_rx_full(flt[18]), .i_rx_cfg(flt[19]),
        .i_rx_clip1(flt[20]), .i_rx_clip2(flt[21]), .i_ce_mc(flt[22]), .i_ce_ifm(flt[23]),
        .i_ce_batt(flt[24]), .i_ce_p5v(flt[25]), .i_ce_p12v(flt[26]),
        .i_ce_n12v(flt[27]), .i_ba_tx(flt[31:28]), .i_ba_rx(flt[35:32]),
        .i_rs_uas(flt[36]));
    fsce_host u_host (.i_ref_clk(i_ref_clk), .i_char(o_char), .i_char_vld(o_char_vld),
        .i_char_idx(o_char_idx));

    initial begin
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    // =========================================================
    // bus tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, e)
    endtask : rd

    task automatic irq_is(input logic e);
        repeat (2) @(posedge i_ref_clk);
        #1;
        `CHK(o_irq, e)
    endtask : irq_is

    // =========================================================
    // fault stimulus and count model
    task automatic set_flt(input logic [36:0] v);
        for (int c = 0; c < 5; c++) begin
            if ((|(v & ~flt & CMASK[c])) && cnt[c] != 4'ha) cnt[c] = cnt[c] + 4'h1;
        end
        @(posedge i_ref_clk);
        flt <= v;
        repeat (3) @(posedge i_ref_clk);
    endtask : set_flt

    task automatic chk_chars();
        logic [6:0] e [13];
        e[0]  = {2'b10, flt[0], 4'h0};
        e[1]  = {3'b100, cnt[0]};
        e[2]  = {1'b1, flt[1], flt[2], flt[3], 1'b0, flt[4], flt[5]};
        e[3]  = {1'b1, flt[6], flt[7], 4'h0};
        e[4]  = {1'b1, flt[8], 1'b0, cnt[1]};
        e[5]  = {1'b1, flt[9], flt[10], flt[11], flt[12], flt[13], flt[14]};
        e[6]  = {1'b1, flt[15], flt[16], flt[17], flt[18], 1'b0, flt[19]};
        e[7]  = {1'b1, flt[20], flt[21], 4'h0};
        e[8]  = {1'b1, flt[22], flt[23], cnt[2]};
        e[9]  = {1'b1, flt[24], flt[25], 1'b0, flt[26], flt[27], 1'b0};
        e[10] = {1'b1, flt[28], flt[29], cnt[3]};
        e[11] = {1'b1, flt[30], flt[31], flt[32], flt[33], flt[34], flt[35]};
        e[12] = {3'b100, cnt[4]};
        for (int i = 0; i < 13; i++) begin
            `CHK(u_host.cap[i], e[i])
        end
        rd(fsce_pkg::ADDR_CNT, {12'h0, cnt[4], cnt[3], cnt[2], cnt[1], cnt[0]});
    endtask : chk_chars

    task automatic poll(input bit twice);
        int unsigned tgt;
        int unsigned k;
        tgt = u_host.n_chars + 13;
        wr(fsce_pkg::ADDR_CTRL, 32'h1);
        repeat (2) @(posedge i_ref_clk);
        #1;
        `CHK({o_char_vld, o_char_idx}, 5'h10)
        if (twice) begin
            rd(fsce_pkg::ADDR_STAT, 32'h103);
            wr(fsce_pkg::ADDR_CTRL, 32'h1);
        end
        for (k = 0; k < 40 && u_host.n_chars < tgt; k++) @(posedge i_ref_clk);
        if (k == 40) begin
            err_count++;
            $display("MISMATCH t=%0t character stream timed out", $time);
            results();
        end
        repeat (20) @(posedge i_ref_clk);
        `CHK(u_host.n_chars, tgt)
        chk_chars();
    endtask : poll

    task automatic results();
        $display("checks_done=%0d err_count=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // =========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        @(posedge i_ref_clk);
        #1;
        `CHK({o_irq, o_char_vld}, 2'b00)
        rd(fsce_pkg::ADDR_CTRL, 32'h0);
        rd(fsce_pkg::ADDR_STAT, 32'h0);
        rd(fsce_pkg::ADDR_MASK, 32'h0);
        rd(fsce_pkg::ADDR_CNT, 32'h0);
        rd(8'h10, 32'h0);
        for (int p = 0; p < 5; p++) begin
            set_flt(PAT[p]);
            poll(p == 2);
        end
        rd(fsce_pkg::ADDR_STAT, 32'h3);
        irq_is(1'b0);
        wr(fsce_pkg::ADDR_MASK, 32'h3);
        irq_is(1'b1);
        wr(fsce_pkg::ADDR_STAT, 32'h3);
        irq_is(1'b0);
        rd(fsce_pkg::ADDR_STAT, 32'h0);
        wr(fsce_pkg::ADDR_MASK, 32'h1);
        poll(1'b0);
        irq_is(1'b1);
        rd(fsce_pkg::ADDR_STAT, 32'h1);
        wr(fsce_pkg::ADDR_STAT, 32'h1);
        irq_is(1'b0);
        for (int i = 0; i < 12; i++) begin
            set_flt(flt | 37'h1000000000);
            set_flt(flt & ~37'h1000000000);
        end
        poll(1'b0);
        wr(fsce_pkg::ADDR_CTRL, 32'h2);
        cnt = '{default: 4'h0};
        rd(fsce_pkg::ADDR_CNT, 32'h0);
        `CHK(u_host.n_order, 0)
        results();
    end
endmodule : testbench
